// ===== inc/adc_readout_map.svh
// Widths, sizes, reset values and timing counts of the result readout block.
// Assumes inclusion by bare name from the design and simulation files.
`ifndef ADC_READOUT_MAP_SVH
`define ADC_READOUT_MAP_SVH

// ----------------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------------
`define RR_DATA_W 12
`define RR_NUM_REGS 4
`define RR_IDX_W 2
`define RR_CNT_W 3
`define RR_FIFO_DEPTH 8

// ----------------------------------------------------------------------------
// Reset values and sign bit position
// ----------------------------------------------------------------------------
`define RR_PTR_FIRST 2'h0
`define RR_DATA_RST 12'h000
`define RR_SIGN_BIT 11

// ----------------------------------------------------------------------------
// Conversion timing, in conversion clocks and system clocks
// ----------------------------------------------------------------------------
`define RR_CONV_CLKS 4'he
`define RR_XFER_CLK 4'hd
`define RR_CONV_CLK_HZ 5000000
`define RR_SYS_CLK_HZ 40000000
`define RR_CONV_DIV (`RR_SYS_CLK_HZ / `RR_CONV_CLK_HZ)

`endif

// ===== inc/adc_readout_pkg.sv
// Types shared by the result readout block.
// Assumes the map header sits on the include path.
package adc_readout_pkg;

  // --------------------------------------------------------------------------
  // Conversion sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_CONV = 2'b10
  } seq_state_e;

endpackage

// ===== rtl/adc_result_readout.sv
// Result readout port of a four-channel sampling converter: result registers,
// circular read pointer, first-result flag, done and busy timing, standby.
// Assumes the conversion engine delivers words in ascending channel order and
// that host pins are asynchronous to ref_clk_i.
//
// Contract
// - Standby pin low enters low-current standby; high returns to normal operation.
// - Result buffers and bus drivers keep working during standby.
// - Four result registers filled in conversion order from register 1.
// - Selected channel subset packs into consecutive registers from register 1.
// - First transfer of a sequence resets pointer to register 1.
// - First-result flag goes high when pointer addresses register 1; after reset the code holds it low until the first transfer.
// - Addressed register drives result bus only while select and read are low.
// - After the sequence, each read rising edge advances the pointer.
// - During a sequence, pointer advances only when next result transfers.
// - Read edge ending the last result returns pointer to register 1.
// - Bipolar results are presented in twos complement.
// - Conversion takes 14 clocks; transfer and done low at 13, high at 14.
// - First-result flag clears when the second result transfers.
// - Reads during a conversion return the current pointer's result.
`timescale 1ns/100ps
`include "adc_readout_map.svh"
module adc_result_readout
  import adc_readout_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Host pins
  input wire logic sample_start_n_i,
  input wire logic standby_low_input_n_i,
  input wire logic chip_sel_n_i,
  input wire logic read_n_i,
  output logic [`RR_DATA_W-1:0] result_bus_o,
  output logic result_bus_oe_o,
  output logic first_result_flag_o,
  output logic conv_done_n_o,
  output logic busy_o,
  // Configuration
  input wire logic [`RR_NUM_REGS-1:0] chan_sel_i,
  input wire logic bipolar_i,
  // Conversion engine
  input wire logic [`RR_DATA_W-1:0] conv_data_i,
  input wire logic conv_valid_i,
  output logic conv_ready_o,
  output logic standby_o
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [`RR_CNT_W-1:0] count_sel(input logic [`RR_NUM_REGS-1:0] sel);
    logic [`RR_CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < `RR_NUM_REGS; i++)
    begin
      n = n + `RR_CNT_W'(sel[i]);
    end
    return n;
  endfunction

  function automatic logic [`RR_IDX_W-1:0] next_idx(input logic [`RR_IDX_W-1:0] idx);
    return idx + 1'b1;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic start_s1_ff;
  logic start_s2_ff;
  logic start_d_ff;
  logic standby_s1_ff;
  logic standby_s2_ff;
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic rd_s1_ff;
  logic rd_s2_ff;
  logic rd_d_ff;
  logic cs_d_ff;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      start_s1_ff <= 1'b1;
      start_s2_ff <= 1'b1;
      start_d_ff <= 1'b1;
      standby_s1_ff <= 1'b1;
      standby_s2_ff <= 1'b1;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      rd_s1_ff <= 1'b1;
      rd_s2_ff <= 1'b1;
      rd_d_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end
    else
    begin
      start_s1_ff <= sample_start_n_i;
      start_s2_ff <= start_s1_ff;
      start_d_ff <= start_s2_ff;
      standby_s1_ff <= standby_low_input_n_i;
      standby_s2_ff <= standby_s1_ff;
      cs_s1_ff <= chip_sel_n_i;
      cs_s2_ff <= cs_s1_ff;
      rd_s1_ff <= read_n_i;
      rd_s2_ff <= rd_s1_ff;
      rd_d_ff <= rd_s2_ff;
      cs_d_ff <= cs_s2_ff;
    end
  end

  logic start_rise;
  logic read_rise;
  logic in_standby;

  assign start_rise = start_s2_ff && !start_d_ff;
  // The read counts only if select was low while the strobe was low.
  assign read_rise = rd_s2_ff && !rd_d_ff && !cs_d_ff;
  assign in_standby = !standby_s2_ff;

  // --------------------------------------------------------------------------
  // Conversion clock divider
  // --------------------------------------------------------------------------
  localparam logic [7:0] DIV_LAST = 8'(`RR_CONV_DIV - 1);
  logic [7:0] div_ff;
  logic conv_tick;

  assign conv_tick = (div_ff == DIV_LAST);

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_ff <= 8'h00;
    end
    else
    begin
      div_ff <= conv_tick ? 8'h00 : div_ff + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Result FIFO between conversion engine and result registers
  // --------------------------------------------------------------------------
  logic [`RR_DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  result_fifo #(
    .W(`RR_DATA_W),
    .D(`RR_FIFO_DEPTH)
  )
  u_fifo
  (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .in_data_i(conv_data_i),
    .in_valid_i(conv_valid_i),
    .in_ready_o(conv_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  seq_state_e state_ff;
  logic [3:0] clk_cnt_ff;
  logic [`RR_IDX_W-1:0] conv_idx_ff;
  logic [`RR_CNT_W-1:0] seq_len_ff;
  logic [`RR_CNT_W-1:0] start_len;
  logic xfer;
  logic conv_end;

  assign start_len = count_sel(chan_sel_i);
  // The register file is loaded on the conversion clock's thirteenth edge.
  assign xfer = (state_ff == SEQ_CONV) && conv_tick && (clk_cnt_ff == `RR_XFER_CLK - 4'h1);
  assign conv_end = (state_ff == SEQ_CONV) && conv_tick && (clk_cnt_ff == `RR_CONV_CLKS - 4'h1);
  assign fifo_pop = xfer;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= SEQ_IDLE;
      clk_cnt_ff <= 4'h0;
      conv_idx_ff <= '0;
      seq_len_ff <= '0;
      busy_o <= 1'b0;
    end
    else
    begin
      case (state_ff)
        SEQ_IDLE:
        begin
          // Standby holds off new sequences but leaves readout alone.
          if (start_rise && !in_standby && (start_len != '0))
          begin
            seq_len_ff <= start_len;
            conv_idx_ff <= '0;
            busy_o <= 1'b1;
            state_ff <= SEQ_WAIT;
          end
        end
        SEQ_WAIT:
        begin
          // An empty FIFO stalls the sequencer until the engine delivers.
          if (fifo_valid && conv_tick)
          begin
            clk_cnt_ff <= 4'h1;
            state_ff <= SEQ_CONV;
          end
        end
        SEQ_CONV:
        begin
          if (conv_tick)
          begin
            clk_cnt_ff <= clk_cnt_ff + 4'h1;
          end
          if (conv_end)
          begin
            clk_cnt_ff <= 4'h0;
            if (`RR_CNT_W'(conv_idx_ff) == seq_len_ff - 1'b1)
            begin
              busy_o <= 1'b0;
              state_ff <= SEQ_IDLE;
            end
            else
            begin
              conv_idx_ff <= next_idx(conv_idx_ff);
              state_ff <= SEQ_WAIT;
            end
          end
        end
        default:
        begin
          state_ff <= SEQ_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      conv_done_n_o <= 1'b1;
    end
    else if (xfer)
    begin
      conv_done_n_o <= 1'b0;
    end
    else if (conv_end)
    begin
      conv_done_n_o <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Result registers
  // --------------------------------------------------------------------------
  logic [`RR_DATA_W-1:0] res_ff [`RR_NUM_REGS];
  logic [`RR_DATA_W-1:0] coded;

  // The engine delivers offset binary; flipping the sign bit gives twos complement.
  always_comb
  begin
    coded = fifo_data;
    coded[`RR_SIGN_BIT] = fifo_data[`RR_SIGN_BIT] ^ bipolar_i;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < `RR_NUM_REGS; i++)
      begin
        res_ff[i] <= `RR_DATA_RST;
      end
    end
    else if (xfer)
    begin
      res_ff[conv_idx_ff] <= coded;
    end
  end

  // --------------------------------------------------------------------------
  // Read pointer and first-result flag
  // --------------------------------------------------------------------------
  logic [`RR_IDX_W-1:0] ptr_ff;
  logic [`RR_CNT_W-1:0] valid_cnt_ff;
  logic ptr_is_last;
  logic next_is_valid;

  assign ptr_is_last = (seq_len_ff != '0) && (`RR_CNT_W'(ptr_ff) == seq_len_ff - 1'b1);
  // A count left from the previous sequence must not let a read advance before the first transfer.
  assign next_is_valid = ((`RR_CNT_W'(ptr_ff) + 1'b1) < valid_cnt_ff) && (ptr_ff < conv_idx_ff);

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ptr_ff <= `RR_PTR_FIRST;
      first_result_flag_o <= 1'b0;
      valid_cnt_ff <= '0;
    end
    else if (xfer)
    begin
      valid_cnt_ff <= `RR_CNT_W'(conv_idx_ff) + 1'b1;
      // A new result moves the pointer onto itself; the first one rewinds it.
      ptr_ff <= conv_idx_ff;
      first_result_flag_o <= (conv_idx_ff == `RR_PTR_FIRST);
    end
    else if (read_rise && !busy_o && ptr_is_last)
    begin
      ptr_ff <= `RR_PTR_FIRST;
      first_result_flag_o <= 1'b1;
    end
    else if (read_rise && (!busy_o || next_is_valid))
    begin
      ptr_ff <= next_idx(ptr_ff);
      first_result_flag_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Data bus drive and standby status
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      result_bus_o <= `RR_DATA_RST;
      result_bus_oe_o <= 1'b0;
      standby_o <= 1'b0;
    end
    else
    begin
      // Drivers stay live in standby so stored results remain readable.
      result_bus_o <= res_ff[ptr_ff];
      result_bus_oe_o <= !cs_s2_ff && !rd_s2_ff;
      standby_o <= in_standby;
    end
  end

endmodule

// ===== rtl/result_fifo.sv
// Small synchronous FIFO of flip-flops with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module result_fifo #(
  parameter int W = 12,
  parameter int D = 8
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Filling side
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Draining side
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  logic ready_ff;

  // Ready comes from a flip-flop so the filling side sees no path from the count logic.
  assign in_ready_o = ready_ff;
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // --------------------------------------------------------------------------
  // Storage and pointers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ready_ff <= 1'b1;
    end
    else if (push && !pop)
    begin
      ready_ff <= (cnt_ff != (AW+1)'(D - 1));
    end
    else if (pop && !push)
    begin
      ready_ff <= 1'b1;
    end
  end

endmodule

// ===== sim/adc_result_readout_asserts.sv
// Concurrent checks on the result readout pins.
// Assumes the bind below; sees only the ports of the readout block.
`timescale 1ns/100ps
`include "adc_readout_map.svh"
module adc_result_readout_asserts
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Host pins
  input wire logic standby_low_input_n_i,
  input wire logic chip_sel_n_i,
  input wire logic read_n_i,
  input wire logic [`RR_DATA_W-1:0] result_bus_o,
  input wire logic result_bus_oe_o,
  input wire logic first_result_flag_o,
  input wire logic conv_done_n_o,
  input wire logic busy_o,
  input wire logic standby_o
);
  // --------------------
  // Properties
  // --------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  bus_enable_gate_a: assert property (result_bus_oe_o |-> $past(!chip_sel_n_i && !read_n_i, 3))
    else $error("bus enabled without select and read");
  done_width_a: assert property ($fell(conv_done_n_o) |-> !conv_done_n_o [*8] ##1 conv_done_n_o)
    else $error("done pulse not one conversion clock");
  done_in_busy_a: assert property ($fell(conv_done_n_o) |-> busy_o)
    else $error("done outside a sequence");
  flag_clear_a: assert property ($fell(first_result_flag_o) && $past(busy_o) |-> $fell(conv_done_n_o))
    else $error("flag cleared away from a transfer");
  reset_state_a: assert property ($rose(arst_n_i) |-> !first_result_flag_o && !busy_o && conv_done_n_o)
    else $error("outputs not at reset state");
  standby_enter_a: assert property (!standby_low_input_n_i [*5] |-> standby_o)
    else $error("standby not entered");
  standby_leave_a: assert property (standby_low_input_n_i [*5] |-> !standby_o)
    else $error("standby not left");
  start_blocked_a: assert property ($rose(busy_o) |-> !standby_o)
    else $error("sequence started in standby");
  bus_hold_a: assert property (busy_o && $changed(result_bus_o) |-> !$past(conv_done_n_o) && $past(conv_done_n_o, 2))
    else $error("bus moved between transfers");

  cover property ($fell(conv_done_n_o) && first_result_flag_o);
  cover property (standby_o && result_bus_oe_o);
  cover property ($fell(busy_o));
endmodule

bind adc_result_readout adc_result_readout_asserts chk (.ref_clk_i, .arst_n_i, .standby_low_input_n_i,
  .chip_sel_n_i, .read_n_i, .result_bus_o, .result_bus_oe_o, .first_result_flag_o, .conv_done_n_o,
  .busy_o, .standby_o);

// ===== sim/host_port_model.sv
// Host processor on the parallel read pins.
// Assumes pins change at falling edges of the block clock.
`timescale 1ns/100ps
`include "adc_readout_map.svh"
module host_port_model
(
  // Clock
  input wire logic ref_clk_i,
  // Read data
  input wire logic [`RR_DATA_W-1:0] result_bus_i,
  input wire logic result_bus_oe_i,
  // Pins driven
  output logic sample_start_n_o,
  output logic standby_n_o,
  output logic chip_sel_n_o,
  output logic read_n_o
);
  // --------------------
  // Access tasks
  // --------------------
  logic [`RR_DATA_W-1:0] rd_data;
  logic rd_ok;

  initial
  begin
    sample_start_n_o = 1'b1;
    standby_n_o = 1'b1;
    chip_sel_n_o = 1'b1;
    read_n_o = 1'b1;
  end

  // Select and strobe stay low until the enable is seen at a rising edge, for at most 8 rising edges.
  task automatic read_word();
    @(negedge ref_clk_i);
    chip_sel_n_o = 1'b0;
    read_n_o = 1'b0;
    repeat (8) if (result_bus_oe_i !== 1'b1) @(posedge ref_clk_i);
    rd_ok = result_bus_oe_i;
    rd_data = result_bus_i;
    @(negedge ref_clk_i);
    read_n_o = 1'b1;
    chip_sel_n_o = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask

  // A strobe with select high must neither enable the bus nor move the pointer.
  task automatic strobe_unselected();
    rd_ok = 1'b0;
    @(negedge ref_clk_i);
    read_n_o = 1'b0;
    repeat (6)
    begin
      @(posedge ref_clk_i);
      rd_ok = rd_ok | result_bus_oe_i;
    end
    @(negedge ref_clk_i);
    read_n_o = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask

  task automatic pulse_start();
    @(negedge ref_clk_i);
    sample_start_n_o = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    sample_start_n_o = 1'b1;
  endtask

  // Standby here lasts well under a millisecond, so 2 us of wake-up is enough.
  task automatic set_standby(input logic low);
    @(negedge ref_clk_i);
    standby_n_o = !low;
    if (!low) repeat (80) @(negedge ref_clk_i);
  endtask
endmodule

// ===== sim/tb_adc_result_readout.sv
// Self-checking bench of the result readout block.
// Assumes the host model and the checker compile alongside.
`timescale 1ns/100ps
`include "adc_readout_map.svh"
module tb_adc_result_readout;
  // --------------------
  // Set-up
  // --------------------
  logic ref_clk_i;
  logic arst_n_i;
  logic [`RR_NUM_REGS-1:0] chan_sel;
  logic bipolar;
  logic [`RR_DATA_W-1:0] conv_data;
  logic conv_valid;
  logic start_n, standby_n, cs_n, rd_n, oe, flag, done_n, busy, ready, standby;
  logic [`RR_DATA_W-1:0] bus;
  int n_fail;
  int n_compared;
  logic [`RR_DATA_W-1:0] words [8] = '{12'h123, 12'h456, 12'h789, 12'habc, 12'h000, 12'hfff, 12'h7ff, 12'h5a5};
  int order [4] = '{6, 4, 5, 6};

  adc_result_readout dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .sample_start_n_i(start_n),
    .standby_low_input_n_i(standby_n), .chip_sel_n_i(cs_n), .read_n_i(rd_n), .result_bus_o(bus),
    .result_bus_oe_o(oe), .first_result_flag_o(flag), .conv_done_n_o(done_n), .busy_o(busy),
    .chan_sel_i(chan_sel), .bipolar_i(bipolar), .conv_data_i(conv_data), .conv_valid_i(conv_valid),
    .conv_ready_o(ready), .standby_o(standby));
  host_port_model host (.ref_clk_i(ref_clk_i), .result_bus_i(bus), .result_bus_oe_i(oe),
    .sample_start_n_o(start_n), .standby_n_o(standby_n), .chip_sel_n_o(cs_n), .read_n_o(rd_n));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input string what, input logic [`RR_DATA_W-1:0] seen, input logic [`RR_DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_busy(input logic lvl);
    repeat (2000) if (busy !== lvl) @(negedge ref_clk_i);
    check("busy", 12'(busy), 12'(lvl));
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    test_done();
  end

  // --------------------
  // Tests
  // --------------------
  initial
  begin
    arst_n_i = 1'b0;
    chan_sel = 4'h0;
    bipolar = 1'b0;
    conv_data = 12'h000;
    conv_valid = 1'b0;
    repeat (16) @(negedge ref_clk_i);
    check("reset flag", 12'(flag), 12'h000);
    check("reset done", 12'(done_n), 12'h001);
    check("reset oe", 12'(oe), 12'h000);
    arst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      check("ready", 12'(ready), 12'h001);
      conv_data = words[i];
      conv_valid = 1'b1;
      @(negedge ref_clk_i);
    end
    conv_valid = 1'b0;
    check("ready full", 12'(ready), 12'h000);
    $display("test reset and fill done");
    // Four channels, each result read twice after its done pulse falls.
    chan_sel = 4'hf;
    host.pulse_start();
    wait_busy(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      repeat (300) if (done_n !== 1'b0) @(negedge ref_clk_i);
      check("done at transfer", 12'(done_n), 12'h000);
      check("flag at transfer", 12'(flag), 12'(k == 0));
      repeat (2)
      begin
        host.read_word();
        check("oe", 12'(host.rd_ok), 12'h001);
        check("result", host.rd_data, words[k]);
      end
    end
    wait_busy(1'b0);
    $display("test read during sequence done");
    // Three channels in bipolar form, read in standby after busy falls.
    chan_sel = 4'hb;
    bipolar = 1'b1;
    host.pulse_start();
    wait_busy(1'b1);
    wait_busy(1'b0);
    host.set_standby(1'b1);
    repeat (6) @(negedge ref_clk_i);
    check("standby", 12'(standby), 12'h001);
    for (int k = 0; k < 4; k++)
    begin
      host.read_word();
      check("standby read", host.rd_data, words[order[k]] ^ 12'h800);
      if (k == 0)
        check("flag after wrap", 12'(flag), 12'h001);
    end
    host.strobe_unselected();
    check("unselected oe", 12'(host.rd_ok), 12'h000);
    host.read_word();
    check("unselected no advance", host.rd_data, words[4] ^ 12'h800);
    host.pulse_start();
    repeat (40) @(negedge ref_clk_i);
    check("busy in standby", 12'(busy), 12'h000);
    host.set_standby(1'b0);
    check("awake", 12'(standby), 12'h000);
    $display("test standby done");
    chan_sel = 4'h0;
    host.pulse_start();
    repeat (40) @(negedge ref_clk_i);
    check("busy no channels", 12'(busy), 12'h000);
    $display("test empty selection done");
    test_done();
  end
endmodule
